// ### verilog/scs_consts.vh
// register offsets, field positions, reset values and timing for the system clock selector
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SCS_ADR_CLK_SELECT      8'h00
`define SCS_ADR_INT_OSC_CTRL    8'h04
`define SCS_ADR_INT_OSC_CAL     8'h08
`define SCS_ADR_LF_OSC_CTRL     8'h0C
`define SCS_ADR_EXT_OSC_CTRL    8'h10
`define SCS_ADR_MULT_LOOP_CTRL  8'h14
`define SCS_ADR_STATUS          8'h18

// ****************************************************************
// source select codes
// ****************************************************************
`define SCS_SRC_INT             2'h0
`define SCS_SRC_EXT             2'h1
`define SCS_SRC_PLL             2'h2
`define SCS_SRC_LFO             2'h3

// ****************************************************************
// field positions
// ****************************************************************
`define SCS_BIT_OSC_EN          7
`define SCS_BIT_OSC_RDY         6
`define SCS_BIT_SUSPEND         5
`define SCS_BIT_LOOP_PWR        7
`define SCS_BIT_LOOP_EN         6
`define SCS_BIT_LOOP_LOCK       5
`define SCS_BIT_MISS_EN         0
`define SCS_BIT_MISS_FLAG       1
`define SCS_BIT_SUSP_STAT       2
`define SCS_BIT_SWITCHING       3

// ****************************************************************
// reset values
// ****************************************************************
`define SCS_RST_CLK_SELECT      2'h3
`define SCS_RST_LF_OSC_CTRL     8'hC3
`define SCS_RST_FACTORY_CAL     7'h40

// ****************************************************************
// timing
// ****************************************************************
`define SCS_CLK_MHZ             100
`define SCS_MISS_TIME_US        100
`define SCS_MISS_CYCLES         (`SCS_MISS_TIME_US * `SCS_CLK_MHZ)

`endif

// ### verilog/scs_sync.v
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module scs_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             arst_n,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q  <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // scs_sync

// ### verilog/scs_divider.v
// power-of-two divider for a synchronised clock level
`timescale 1ns/1ps
module scs_divider #(
    parameter CODE_BITS = 3
) (
    // clock and reset
    input  wire                 core_clk,
    input  wire                 arst_n,
    // source and setting
    input  wire                 srcLvl,
    input  wire [CODE_BITS-1:0] code,
    // result
    output reg                  divLvl,
    output reg                  edgeSeen
);
    localparam CNT_W = (1 << CODE_BITS) - 1;

    reg             prev_q;
    reg [CNT_W-1:0] cnt_q;
    wire            rise = srcLvl & ~prev_q;
    reg [CODE_BITS-1:0] code_q;
    wire            cur  = ~|code_q ? srcLvl : cnt_q[code_q - 1'b1];
    wire            nxt  = ~|code ? srcLvl : cnt_q[code - 1'b1];

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q   <= 1'b0;
            cnt_q    <= {CNT_W{1'b0}};
            code_q   <= {CODE_BITS{1'b0}};
            divLvl   <= 1'b0;
            edgeSeen <= 1'b0;
        end else begin
            prev_q   <= srcLvl;
            edgeSeen <= rise;
            if (rise) begin
                cnt_q <= cnt_q + 1'b1;
            end
            // bit k of the edge count toggles every 2^k source periods
            divLvl <= cur;
            // a new code waits until both outputs are low
            if (!cur && !nxt) begin
                code_q <= code;
            end
        end
    end
endmodule // scs_divider

// ### verilog/scs_selector.v
// system clock selector: source choice, dividers, suspend/wake and register file
// Operation
// - two-bit select: 00 internal, 01 external, 11 low-freq, 10 multiplier loop.
// - internal oscillator divider code 000 divides by 1, up to 128 at 111.
// - external clock divider code 000 passes clock, up to divide-by-128 at 111.
// - low-freq divider: 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// - loop selection gives about 50 MHz; loop runs even when unselected.
// - source may change while running; firmware picks only settled sources.
// - missing selected clock with detection enabled raises a reset.
// - after any reset the system runs from the low-frequency oscillator.
// - low-freq oscillator has firmware enable bit and four-bit fine tune.
// - internal oscillator starts at factory calibration; writes replace it.
// - internal oscillator enable starts it; selectable at once, no wait.
// - suspend stops internal oscillator; its system clock stays stopped.
// - wake on enabled comparator 0 low or receive line falling edge.
// - on wake the core and stopped peripherals resume.
// - external clock stays available to timers and counter array.
// - loop enabled only when both power and enable bits are set.
// - loop multiplies by eight; system path divided to at most 50 MHz.
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_selector #(
    parameter MISS_CYCLES = `SCS_MISS_CYCLES,
    parameter [6:0] FACTORY_CAL = `SCS_RST_FACTORY_CAL
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // oscillator and loop clocks, asynchronous
    input  wire        intOscClk,
    input  wire        extClk,
    input  wire        lowFreqOscClk,
    input  wire        loopDivClk,
    // oscillator status, asynchronous
    input  wire        intOscReady,
    input  wire        lowFreqOscReady,
    input  wire        loopLocked,
    // wake sources
    input  wire        cmp0Enable,
    input  wire        cmp0Out,
    input  wire        uartRx,
    // oscillator controls
    output reg         intOscRun,
    output reg  [6:0]  intOscTrim,
    output reg         lowFreqOscRun,
    output reg  [3:0]  lowFreqOscTrim,
    output reg         loopPowerOn,
    output reg         loopRun,
    // clocks and missing-clock reset out
    output reg         systemClock,
    output reg         extPeriphClock,
    output reg         missingClockReset
);
    // ****************************************************************
    // switch states
    // ****************************************************************
    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_PARK  = 2'b01;
    localparam [1:0] ST_ARM   = 2'b10;
    localparam [1:0] ST_SLEEP = 2'b11;
    localparam       MISS_W   = 24;

    // ****************************************************************
    // registers
    // ****************************************************************
    reg  [1:0]  clkSelect_q;
    reg         intOscEnable_q;
    reg         suspend_q;
    reg  [2:0]  intOscDivider_q;
    reg  [6:0]  intOscCal_q;
    reg         lowFreqOscEnable_q;
    reg  [3:0]  lowFreqOscFineTune_q;
    reg  [1:0]  lowFreqOscDivider_q;
    reg  [2:0]  extClockDivider_q;
    reg         loopPowerEnable_q;
    reg         loopEnable_q;
    reg         missEnable_q;
    reg         missFlag_q;
    reg  [1:0]  activeSrc_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [MISS_W-1:0] missCnt_q;
    reg         rxPrev_q;

    // ****************************************************************
    // synchronised pin levels
    // ****************************************************************
    wire [8:0]  pinSync;
    wire        intLvl   = pinSync[0];
    wire        extLvl   = pinSync[1];
    wire        lfoLvl   = pinSync[2];
    wire        loopLvl  = pinSync[3];
    wire        intRdy   = pinSync[4];
    wire        lfoRdy   = pinSync[5];
    wire        loopLck  = pinSync[6];
    wire        cmpLvl   = pinSync[7];
    wire        rxLvl    = pinSync[8];

    scs_sync #(
        .WIDTH(9)
    ) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .asyncIn  ({uartRx, cmp0Out, loopLocked, lowFreqOscReady,
                    intOscReady, loopDivClk, lowFreqOscClk, extClk, intOscClk}),
        .syncOut  (pinSync)
    );

    // ****************************************************************
    // dividers
    // ****************************************************************
    wire        intDiv;
    wire        extDiv;
    wire        lfoDiv;
    wire        intEdge;
    wire        extEdge;
    wire        lfoEdge;

    scs_divider #(
        .CODE_BITS(3)
    ) u_int_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .srcLvl   (intLvl),
        .code     (intOscDivider_q),
        .divLvl   (intDiv),
        .edgeSeen (intEdge)
    );

    scs_divider #(
        .CODE_BITS(3)
    ) u_ext_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .srcLvl   (extLvl),
        .code     (extClockDivider_q),
        .divLvl   (extDiv),
        .edgeSeen (extEdge)
    );

    // low-freq codes run the other way: 00 is the deepest division
    scs_divider #(
        .CODE_BITS(3)
    ) u_lfo_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .srcLvl   (lfoLvl),
        .code     ({1'b0, ~lowFreqOscDivider_q}),
        .divLvl   (lfoDiv),
        .edgeSeen (lfoEdge)
    );

    // loop path arrives already divided from the eight-times multiplier
    reg  loopPrev_q;
    wire loopEdge = loopLvl & ~loopPrev_q;

    // ****************************************************************
    // source multiplexing
    // ****************************************************************
    function srcLevel;
        input [1:0] sel;
        input       i;
        input       e;
        input       p;
        input       l;
        begin
            case (sel)
                `SCS_SRC_INT: srcLevel = i;
                `SCS_SRC_EXT: srcLevel = e;
                `SCS_SRC_PLL: srcLevel = p;
                default:      srcLevel = l;
            endcase
        end
    endfunction

    wire curLvl  = srcLevel(activeSrc_q, intDiv, extDiv, loopLvl, lfoDiv);
    wire newLvl  = srcLevel(clkSelect_q, intDiv, extDiv, loopLvl, lfoDiv);
    wire curEdge = srcLevel(activeSrc_q, intEdge, extEdge, loopEdge, lfoEdge);

    // ****************************************************************
    // suspend and wake
    // ****************************************************************
    wire rxFall  = rxPrev_q & ~rxLvl;
    wire wake    = (cmp0Enable & ~cmpLvl) | rxFall;
    wire intSlept = suspend_q && (activeSrc_q == `SCS_SRC_INT);

    // ****************************************************************
    // register bus
    // ****************************************************************
    wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrLow  = busReq & wb_we_i & wb_sel_i[0];
    wire [7:0] wd = wb_dat_i[7:0];

    reg [7:0] rdData;
    always @* begin
        rdData = 8'h00;
        case (wb_adr_i)
            `SCS_ADR_CLK_SELECT:     rdData = {6'h00, clkSelect_q};
            `SCS_ADR_INT_OSC_CTRL:   rdData = {intOscEnable_q, intRdy, suspend_q,
                                               2'b00, intOscDivider_q};
            `SCS_ADR_INT_OSC_CAL:    rdData = {1'b0, intOscCal_q};
            `SCS_ADR_LF_OSC_CTRL:    rdData = {lowFreqOscEnable_q, lfoRdy,
                                               lowFreqOscFineTune_q, lowFreqOscDivider_q};
            `SCS_ADR_EXT_OSC_CTRL:   rdData = {5'h00, extClockDivider_q};
            `SCS_ADR_MULT_LOOP_CTRL: rdData = {loopPowerEnable_q, loopEnable_q,
                                               loopLck, 5'h00};
            `SCS_ADR_STATUS:         rdData = {2'b00, activeSrc_q,
                                               (state_q == ST_PARK || state_q == ST_ARM),
                                               intSlept, missFlag_q, missEnable_q};
            default:                 rdData = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            if (busReq && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, rdData};
            end
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkSelect_q          <= `SCS_RST_CLK_SELECT;
            intOscEnable_q       <= 1'b0;
            suspend_q            <= 1'b0;
            intOscDivider_q      <= 3'h0;
            intOscCal_q          <= FACTORY_CAL;
            lowFreqOscEnable_q   <= 1'b1;
            lowFreqOscFineTune_q <= 4'h0;
            lowFreqOscDivider_q  <= 2'h3;
            extClockDivider_q    <= 3'h0;
            loopPowerEnable_q    <= 1'b0;
            loopEnable_q         <= 1'b0;
            missEnable_q         <= 1'b0;
        end else begin
            // firmware is trusted to pick only enabled, settled sources
            if (wrLow && wb_adr_i == `SCS_ADR_CLK_SELECT) begin
                clkSelect_q <= wd[1:0];
            end
            if (wrLow && wb_adr_i == `SCS_ADR_INT_OSC_CTRL) begin
                intOscEnable_q  <= wd[`SCS_BIT_OSC_EN];
                intOscDivider_q <= wd[2:0];
            end
            // a suspend write in the same cycle as a wake wins
            if (wrLow && wb_adr_i == `SCS_ADR_INT_OSC_CTRL && wd[`SCS_BIT_SUSPEND]) begin
                suspend_q <= 1'b1;
            end else if (wrLow && wb_adr_i == `SCS_ADR_INT_OSC_CTRL) begin
                suspend_q <= 1'b0;
            end else if (suspend_q && wake) begin
                suspend_q <= 1'b0;
            end
            if (wrLow && wb_adr_i == `SCS_ADR_INT_OSC_CAL) begin
                intOscCal_q <= wd[6:0];
            end
            if (wrLow && wb_adr_i == `SCS_ADR_LF_OSC_CTRL) begin
                lowFreqOscEnable_q   <= wd[`SCS_BIT_OSC_EN];
                lowFreqOscFineTune_q <= wd[5:2];
                lowFreqOscDivider_q  <= wd[1:0];
            end
            if (wrLow && wb_adr_i == `SCS_ADR_EXT_OSC_CTRL) begin
                extClockDivider_q <= wd[2:0];
            end
            if (wrLow && wb_adr_i == `SCS_ADR_MULT_LOOP_CTRL) begin
                loopPowerEnable_q <= wd[`SCS_BIT_LOOP_PWR];
                loopEnable_q      <= wd[`SCS_BIT_LOOP_EN];
            end
            if (wrLow && wb_adr_i == `SCS_ADR_STATUS) begin
                missEnable_q <= wd[`SCS_BIT_MISS_EN];
            end
        end
    end

    // ****************************************************************
    // glitch-free switch
    // ****************************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (intSlept) begin
                    state_d = curLvl ? ST_RUN : ST_SLEEP;
                end else if (clkSelect_q != activeSrc_q) begin
                    state_d = ST_PARK;
                end
            end
            // wait for the old clock's low phase, then hold low
            ST_PARK:  state_d = curLvl ? ST_PARK : ST_ARM;
            // release only while the new clock is low, so no short high
            ST_ARM:   state_d = newLvl ? ST_ARM : ST_RUN;
            ST_SLEEP: state_d = (suspend_q || curLvl) ? ST_SLEEP : ST_RUN;
            default:  state_d = ST_RUN;
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= ST_RUN;
            activeSrc_q <= `SCS_RST_CLK_SELECT;
            systemClock <= 1'b0;
            loopPrev_q  <= 1'b0;
            rxPrev_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            loopPrev_q <= loopLvl;
            rxPrev_q   <= rxLvl;
            if (state_q == ST_ARM && !newLvl) begin
                activeSrc_q <= clkSelect_q;
            end
            // a high phase always finishes before the clock is held low
            systemClock <= (state_q == ST_RUN || state_q == ST_PARK) && curLvl;
        end
    end

    // ****************************************************************
    // missing clock detector
    // ****************************************************************
    // counts core cycles with no edge from the running source; the
    // limitation is that sources must stay below half the core rate
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            missCnt_q         <= {MISS_W{1'b0}};
            missFlag_q        <= 1'b0;
            missingClockReset <= 1'b0;
        end else begin
            if (curEdge || !missEnable_q || intSlept || state_q != ST_RUN) begin
                missCnt_q <= {MISS_W{1'b0}};
            end else if (missCnt_q != MISS_CYCLES[MISS_W-1:0]) begin
                missCnt_q <= missCnt_q + 1'b1;
            end
            missingClockReset <= missEnable_q && (state_q == ST_RUN) &&
                                 (missCnt_q == MISS_CYCLES[MISS_W-1:0]);
            if (missingClockReset) begin
                missFlag_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // oscillator and loop controls
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            intOscRun      <= 1'b0;
            intOscTrim     <= FACTORY_CAL;
            lowFreqOscRun  <= 1'b1;
            lowFreqOscTrim <= 4'h0;
            loopPowerOn    <= 1'b0;
            loopRun        <= 1'b0;
            extPeriphClock <= 1'b0;
        end else begin
            // no settle wait: the oscillator runs as soon as enabled
            intOscRun      <= intOscEnable_q & ~suspend_q;
            intOscTrim     <= intOscCal_q;
            lowFreqOscRun  <= lowFreqOscEnable_q;
            lowFreqOscTrim <= lowFreqOscFineTune_q;
            loopPowerOn    <= loopPowerEnable_q;
            // loop kept running whatever the system source is
            loopRun        <= loopPowerEnable_q & loopEnable_q;
            extPeriphClock <= extLvl;
        end
    end
endmodule // scs_selector

// ### verification/scs_selector_checker.sv
// port assertions for the system clock selector
`timescale 1ns/1ps
module scs_selector_checker #(
    parameter       MISS_CYCLES = 50,
    parameter [6:0] FACTORY_CAL = 7'h40
) (
    // clock and reset
    input wire        core_clk,
    input wire        arst_n,
    // register bus
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    // sources and controls
    input wire        extClk,
    input wire        intOscRun,
    input wire [6:0]  intOscTrim,
    input wire        lowFreqOscRun,
    input wire [3:0]  lowFreqOscTrim,
    input wire        loopPowerOn,
    input wire        loopRun,
    input wire        systemClock,
    input wire        extPeriphClock,
    input wire        missingClockReset
);
    // ********
    // checks
    // ********
    // the master still holds the bus in the ack cycle, so $past gives the written byte
    wire wrDone = wb_ack_o & wb_we_i & wb_sel_i[0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    reset_state_a: assert property ($rose(arst_n) |-> lowFreqOscRun && !systemClock
        && intOscTrim == FACTORY_CAL) else $error("wrong state after reset");
    cal_write_a: assert property (wrDone && wb_adr_i == 8'h08 |=>
        intOscTrim == $past(wb_dat_i[6:0])) else $error("calibration write lost");
    lf_write_a: assert property (wrDone && wb_adr_i == 8'h0C |=>
        lowFreqOscRun == $past(wb_dat_i[7]) && lowFreqOscTrim == $past(wb_dat_i[5:2]))
        else $error("low-frequency control write lost");
    int_run_a: assert property (wrDone && wb_adr_i == 8'h04 |=>
        intOscRun == ($past(wb_dat_i[7]) && !$past(wb_dat_i[5])))
        else $error("internal oscillator run level wrong");
    loop_gate_a: assert property (wrDone && wb_adr_i == 8'h14 |=>
        loopRun == ($past(wb_dat_i[7]) && $past(wb_dat_i[6]))
        && loopPowerOn == $past(wb_dat_i[7])) else $error("loop enable not gated");
    clk_high_a: assert property ($rose(systemClock) |=> systemClock)
        else $error("system clock high for one cycle");
    clk_low_a: assert property ($fell(systemClock) |=> !systemClock)
        else $error("system clock low for one cycle");
    ext_follow_a: assert property (extClk [*4] |-> extPeriphClock)
        else $error("peripheral copy of external clock lost");
    cover property ($rose(missingClockReset));
    cover property ($fell(intOscRun));
    cover property ($rose(loopRun));
endmodule // scs_selector_checker

// ### verification/scs_osc_model.sv
// behavioural oscillators, loop tap and external clock source
`timescale 1ns/1ps
module scs_osc_model #(
    parameter INT_HALF  = 30,
    parameter EXT_HALF  = 40,
    parameter LOOP_HALF = 20,
    parameter LF_HALF   = 200
) (
    // controls
    input  wire intOscRun,
    input  wire lowFreqOscRun,
    input  wire loopRun,
    input  wire extStop,
    // clocks and status
    output reg  intOscClk,
    output reg  extClk,
    output reg  lowFreqOscClk,
    output reg  loopDivClk,
    output wire intOscReady,
    output wire lowFreqOscReady,
    output wire loopLocked
);
    // ********
    // sources
    // ********
    // a stopped source parks low after its current phase, never a short pulse
    assign intOscReady     = intOscRun;
    assign lowFreqOscReady = lowFreqOscRun;
    assign loopLocked      = loopRun;
    initial begin
        intOscClk = 1'b0;
        forever #INT_HALF intOscClk = intOscRun & ~intOscClk;
    end
    initial begin
        extClk = 1'b0;
        forever #EXT_HALF extClk = ~extClk & ~extStop;
    end
    initial begin
        lowFreqOscClk = 1'b0;
        forever #LF_HALF lowFreqOscClk = lowFreqOscRun & ~lowFreqOscClk;
    end
    initial begin
        loopDivClk = 1'b0;
        forever #LOOP_HALF loopDivClk = loopRun & ~loopDivClk;
    end
endmodule // scs_osc_model

// ### verification/tb.sv
// self-checking bench for the system clock selector
`timescale 1ns/1ps
`define CHK(g, e) chk((g), (e))
module tb;
    localparam       MISS_CYCLES = 50;
    localparam [6:0] FACTORY_CAL = 7'h40;
    reg         core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    reg         cmp0Enable, cmp0Out, uartRx, extStop;
    reg  [7:0]  wb_adr_i;
    reg  [3:0]  wb_sel_i;
    reg  [31:0] wb_dat_i, v;
    wire [31:0] wb_dat_o;
    wire [6:0]  intOscTrim;
    wire [3:0]  lowFreqOscTrim;
    wire        wb_ack_o, intOscClk, extClk, lowFreqOscClk, loopDivClk, intOscReady;
    wire        lowFreqOscReady, loopLocked, intOscRun, lowFreqOscRun, loopPowerOn, loopRun;
    wire        systemClock, extPeriphClock, missingClockReset;
    reg  [31:0] expQ[$];
    integer     failures = 0, comparisons = 0, seed, rises, s, c, k, n, p;
    time        t0;
    scs_selector #(.MISS_CYCLES(MISS_CYCLES), .FACTORY_CAL(FACTORY_CAL)) uut (.*);
    scs_osc_model #(.INT_HALF(30), .EXT_HALF(40), .LOOP_HALF(20), .LF_HALF(200)) osc (.*);
    task chk(input [31:0] g, input [31:0] e);
        begin
            comparisons++;
            if (g !== e) begin
                failures++;
                $display("MISMATCH at %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    // read expectations go to the queue, the monitor below compares them
    task wbx(input [7:0] a, input w, input [31:0] d, input [31:0] e);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            if (!w)
                expQ.push_back(e);
            @(posedge core_clk);
            while (wb_ack_o !== 1'b1)
                @(posedge core_clk);
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task do_reset;
        begin
            arst_n <= 1'b0;
            repeat (10) @(posedge core_clk);
            arst_n <= 1'b1;
            @(posedge core_clk);
        end
    endtask
    task complete_run;
        begin
            $display("comparisons=%0d failures=%0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            `CHK(wb_dat_o, expQ.size() ? expQ.pop_front() : 32'hDEAD_BEEF);
    end
    always @(posedge systemClock) rises++;
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #400_000;
        failures++;
        complete_run;
    end
    initial begin
        {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, cmp0Enable, cmp0Out, extStop} = 7'h00;
        {uartRx, wb_adr_i, wb_sel_i, wb_dat_i, seed} = {1'b1, 8'h00, 4'h1, 32'h0000_0000, 32'h0001_40F9};
        do_reset;
        wbx(8'h00, 0, 0, 32'h0000_0003);
        wbx(8'h0C, 0, 0, 32'h0000_00C3);
        wbx(8'h08, 0, 0, FACTORY_CAL);
        wbx(8'h1C, 0, 0, 32'h0000_0000);
        v = $random(seed);
        wbx(8'h08, 1, v, 0);
        wbx(8'h08, 0, 0, {25'h0, v[6:0]});
        wbx(8'h0C, 1, {24'h0, 2'b11, v[11:8], 2'b11}, 0);
        wbx(8'h0C, 0, 0, {24'h0, 2'b11, v[11:8], 2'b11});
        for (k = 0; k < 4; k++) begin
            wbx(8'h14, 1, k << 6, 0);
            `CHK({loopPowerOn, loopRun}, {k[1], k[1] & k[0]});
        end
        for (s = 0; s < 4; s++) begin
            for (c = 0; c < ((s == 3) ? 4 : (s == 2) ? 1 : 8); c++) begin
                case (s)
                    0: wbx(8'h04, 1, 32'h0000_0080 | c, 0);
                    1: wbx(8'h10, 1, c, 0);
                    2: wbx(8'h14, 1, 32'h0000_00C0, 0);
                    default: wbx(8'h0C, 1, 32'h0000_00C0 | c, 0);
                endcase
                wbx(8'h00, 1, s, 0);
                @(posedge systemClock);
                @(posedge systemClock);
                t0 = $time;
                @(posedge systemClock);
                p = (s == 0) ? 60 : (s == 1) ? 80 : (s == 2) ? 40 : 400;
                p = p * ((s == 3) ? (8 >> c) : (1 << c));
                `CHK($time - t0 + 20 > p && $time - t0 < p + 20, 1'b1);
                wbx(8'h18, 0, 0, s << 4);
            end
        end
        wbx(8'h04, 1, 32'h0000_0080, 0);
        wbx(8'h00, 1, 0, 0);
        repeat (800) @(posedge core_clk);
        for (k = 0; k < 2; k++) begin
            wbx(8'h04, 1, 32'h0000_00A0, 0);
            repeat (4) @(posedge core_clk);
            rises = 0;
            repeat (60) @(posedge core_clk);
            `CHK({rises[7:0], intOscRun}, 9'h000);
            wbx(8'h18, 0, 0, 32'h0000_0004);
            if (k == 0)
                uartRx <= 1'b0;
            else
                cmp0Enable <= 1'b1;
            for (n = 0; n < 200 && systemClock !== 1'b1; n++) @(posedge core_clk);
            `CHK(n < 200, 1'b1);
            wbx(8'h04, 0, 0, 32'h0000_00C0);
            uartRx <= 1'b1;
            cmp0Enable <= 1'b0;
        end
        wbx(8'h10, 1, 0, 0);
        wbx(8'h00, 1, 1, 0);
        wbx(8'h18, 1, 1, 0);
        repeat (600) @(posedge core_clk);
        extStop <= 1'b1;
        for (n = 0; n < 200 && missingClockReset !== 1'b1; n++) @(posedge core_clk);
        `CHK(n > MISS_CYCLES - 12 && n < MISS_CYCLES + 20, 1'b1);
        wbx(8'h18, 0, 0, 32'h0000_0013);
        extStop <= 1'b0;
        do_reset;
        wbx(8'h00, 0, 0, 32'h0000_0003);
        wbx(8'h18, 0, 0, 32'h0000_0030);
        complete_run;
    end
endmodule // tb
bind scs_selector scs_selector_checker #(.MISS_CYCLES(MISS_CYCLES), .FACTORY_CAL(FACTORY_CAL)) chk (.*);
